// *** logic/mck_unit.sv ***
/*
 machine check and checkstop unit: gathers error sources, takes the
 exception or enters checkstop, holds config and save/restore registers.
 assumes the core applies machineStateOut on the edge after
 machineStateLoad, and honours haltCore at once.
*/
`timescale 1ns/1ns
`default_nettype none
module mck_unit (
    input wire logic clock,
    input wire logic nrst,
    input wire logic machineCheckPinN,
    input wire logic checkstopInputN,
    input wire logic transferErrorAck,
    input wire logic busAddrParityErr,
    input wire logic busDataParityErr,
    input wire logic l2DataParityErr,
    input wire logic [31:0] machineState,
    input wire logic recoverableIn,
    input wire logic [31:0] currentEa,
    input wire logic sprWrite,
    input wire mck_pkg::mck_spr_t sprSel,
    input wire logic [31:0] sprWrData,
    output logic [31:0] sprRdData,
    output logic [31:0] machineStateOut,
    output logic machineStateLoad,
    output logic [31:0] fetchAddr,
    output logic fetchRedirect,
    output logic haltCore,
    output logic checkstopOutput,
    output logic checkstopOutputOe_n
);
    logic rstN; // synchronised reset
    logic [1:0] pinsSync; // {pin, checkstop in}, active low
    logic pinPrev_q, pinPrev_d; // last synced pin level
    logic pinEvent; // one clean assertion event
    logic ckstpInAct; // external checkstop request
    logic meEff; // enable, masked while our update is in flight
    mck_pkg::mck_cause_t causeNow; // gated sources this cycle
    logic anyCause;
    logic [31:0] statusImage, stateImage, vectorAddr;
    mck_pkg::mck_state_t state_q, state_d;
    logic [31:0] cfg_q, cfg_d; // configuration register
    logic [31:0] save_restore_address_q, save_restore_address_d; // save/restore address
    logic [31:0] save_restore_status_q, save_restore_status_d; // save/restore status
    logic [31:0] rd_q, rd_d;
    logic [31:0] msrOut_q, msrOut_d;
    logic load_q, load_d;
    logic [31:0] fetch_q, fetch_d;
    logic redir_q, redir_d;
    logic halt_q, halt_d;
    logic oen_q, oen_d;
    logic ckVal_q; // open-drain low level

    // reset release through two flops; assertion stays asynchronous
    mck_sync #(.WIDTH(1), .RESET_VAL(1'b0)) u_rst (
        .clock(clock),
        .nrst(nrst),
        .d(1'b1),
        .q(rstN)
    );

    // pins idle high, so the synchroniser resets high
    mck_sync #(.WIDTH(2), .RESET_VAL(2'b11)) u_pins (
        .clock(clock),
        .nrst(rstN),
        .d({machineCheckPinN, checkstopInputN}),
        .q(pinsSync)
    );

    mck_entry_image u_img (
        .machineState(machineState),
        .causes(causeNow),
        .recoverable(recoverableIn),
        .statusImage(statusImage),
        .stateImage(stateImage),
        .vectorAddr(vectorAddr)
    );

    // edge, not level: a held pin must not retrigger after the handler
    assign pinEvent = pinPrev_q & ~pinsSync[1]; // see RULE_22
    assign ckstpInAct = ~pinsSync[0]; // see RULE_20
    // the core still shows the old enable until it loads our image
    assign meEff = machineState[mck_pkg::MSR_ME_BIT] & ~load_q;

    // pin and parity source gating by configuration enables
    always_comb
    begin
        causeNow.pin = pinEvent & cfg_q[mck_pkg::CFG_PIN_EN_BIT]; // see RULE_03
        causeNow.addrParity = busAddrParityErr & cfg_q[mck_pkg::CFG_ADDR_PAR_BIT]; // see RULE_04
        causeNow.dataParity = busDataParityErr & cfg_q[mck_pkg::CFG_DATA_PAR_BIT]; // see RULE_05
        // may arrive any time after the access; no ordering kept
        causeNow.transferErr = transferErrorAck; // see RULE_08 see RULE_09
        causeNow.l2DataParity = l2DataParityErr;
        anyCause = |causeNow;
    end

    // next values for the whole unit
    always_comb
    begin
        state_d = state_q;
        cfg_d = cfg_q;
        save_restore_address_d = save_restore_address_q;
        save_restore_status_d = save_restore_status_q;
        rd_d = rd_q;
        msrOut_d = msrOut_q;
        load_d = 1'b0;
        fetch_d = fetch_q;
        redir_d = 1'b0;
        halt_d = halt_q;
        oen_d = oen_q;
        pinPrev_d = pinsSync[1];
        case (state_q)
            mck_pkg::MCK_RUN:
            begin
                // software moves; the only path that touches the flag
                if (sprWrite)
                begin
                    case (sprSel)
                        mck_pkg::MCK_SPR_CONFIG: cfg_d = sprWrData; // see RULE_06
                        mck_pkg::MCK_SPR_ADDR: save_restore_address_d = sprWrData;
                        mck_pkg::MCK_SPR_STATUS: save_restore_status_d = sprWrData;
                        default: ;
                    endcase
                end
                // read data follows the select each cycle
                case (sprSel)
                    mck_pkg::MCK_SPR_CONFIG: rd_d = cfg_q;
                    mck_pkg::MCK_SPR_ADDR: rd_d = save_restore_address_q;
                    mck_pkg::MCK_SPR_STATUS: rd_d = save_restore_status_q;
                    default: rd_d = 32'h0000_0000;
                endcase
                if (ckstpInAct || (anyCause && !meEff))
                begin
                    // disabled check or forced stop
                    state_d = mck_pkg::MCK_STOP; // see RULE_02 see RULE_20 see RULE_21
                    halt_d = 1'b1; // see RULE_18
                    oen_d = 1'b0; // see RULE_19
                end
                else if (anyCause)
                begin
                    // exception entry overrides a same-cycle software move
                    save_restore_address_d = currentEa; // see RULE_10
                    save_restore_status_d = statusImage; // see RULE_01 see RULE_11
                    msrOut_d = stateImage; // see RULE_15
                    load_d = 1'b1;
                    fetch_d = vectorAddr; // see RULE_16
                    redir_d = 1'b1;
                end
            end
            mck_pkg::MCK_STOP:
            begin
                // frozen until hard reset: nothing changes
                pinPrev_d = pinPrev_q; // see RULE_18
            end
            default:
            begin
                state_d = mck_pkg::MCK_STOP;
                halt_d = 1'b1;
                oen_d = 1'b0;
            end
        endcase
    end

    // register stage; hard reset clears the flag, soft reset never reaches here
    always_ff @(posedge clock or negedge rstN)
    begin
        if (!rstN)
        begin
            state_q <= mck_pkg::MCK_RUN;
            cfg_q <= mck_pkg::CFG_RESET; // see RULE_07
            save_restore_address_q <= mck_pkg::SRR_RESET;
            save_restore_status_q <= mck_pkg::SRR_RESET;
            rd_q <= 32'h0000_0000;
            msrOut_q <= 32'h0000_0000;
            load_q <= 1'b0;
            fetch_q <= 32'h0000_0000;
            redir_q <= 1'b0;
            halt_q <= 1'b0;
            oen_q <= 1'b1;
            pinPrev_q <= 1'b1;
            ckVal_q <= 1'b0;
        end
        else
        begin
            state_q <= state_d;
            cfg_q <= cfg_d;
            save_restore_address_q <= save_restore_address_d;
            save_restore_status_q <= save_restore_status_d;
            rd_q <= rd_d;
            msrOut_q <= msrOut_d;
            load_q <= load_d;
            fetch_q <= fetch_d;
            redir_q <= redir_d;
            halt_q <= halt_d;
            oen_q <= oen_d;
            pinPrev_q <= pinPrev_d;
            ckVal_q <= 1'b0;
        end
    end

    assign sprRdData = rd_q;
    assign machineStateOut = msrOut_q;
    assign machineStateLoad = load_q;
    assign fetchAddr = fetch_q;
    assign fetchRedirect = redir_q;
    assign haltCore = halt_q;
    assign checkstopOutput = ckVal_q;
    assign checkstopOutputOe_n = oen_q;

    // checks, all on the core clock
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rstN);

    logic takeNow; // run state with an accepted cause
    assign takeNow = (state_q == mck_pkg::MCK_RUN) && anyCause && meEff && !ckstpInAct;

    chk_take_redirect: assert property ( // see RULE_01
        takeNow |=> fetchRedirect && machineStateLoad ##1 !fetchRedirect)
        else $error("accepted cause did not redirect fetch");
    chk_disabled_stop: assert property ( // see RULE_02
        (state_q == mck_pkg::MCK_RUN) && anyCause && !meEff
        |=> state_q == mck_pkg::MCK_STOP && !fetchRedirect)
        else $error("disabled check did not enter checkstop");
    // a lone masked pin event must leave the unit running, no redirect
    chk_pin_masked: assert property ( // see RULE_03
        (state_q == mck_pkg::MCK_RUN) && pinEvent && !cfg_q[mck_pkg::CFG_PIN_EN_BIT] && !ckstpInAct
        && !transferErrorAck && !l2DataParityErr && !causeNow.addrParity && !causeNow.dataParity
        |=> !fetchRedirect && !haltCore)
        else $error("masked pin raised a cause");
    // parity errors with checking off must neither redirect nor stop
    chk_parity_gate: assert property ( // see RULE_04
        (state_q == mck_pkg::MCK_RUN) && !ckstpInAct && !causeNow.pin && !transferErrorAck && !l2DataParityErr
        && !(busAddrParityErr && cfg_q[mck_pkg::CFG_ADDR_PAR_BIT])
        && !(busDataParityErr && cfg_q[mck_pkg::CFG_DATA_PAR_BIT]) // see RULE_05
        |=> !fetchRedirect && !haltCore)
        else $error("parity cause while checking disabled");
    chk_flag_write_only: assert property ( // see RULE_06
        $changed(cfg_q[mck_pkg::CFG_NOT_COLD_BIT])
        |-> $past(sprWrite) && $past(sprSel) == mck_pkg::MCK_SPR_CONFIG)
        else $error("reset flag changed without a write");
    chk_status_image: assert property ( // see RULE_12
        takeNow |=> save_restore_status_q[20:16] == $past(causeNow)
        && save_restore_status_q[31] == 1'b0 && save_restore_address_q == $past(currentEa)) // see RULE_14
        else $error("status image causes wrong");
    chk_entry_state: assert property ( // see RULE_15
        takeNow |=> !machineStateOut[mck_pkg::MSR_ME_BIT] && !machineStateOut[15]
        && machineStateOut[mck_pkg::MSR_LE_BIT] == $past(machineState[mck_pkg::MSR_ILE_BIT]))
        else $error("entry state image wrong");
    chk_vector_addr: assert property ( // see RULE_16
        takeNow |=> fetchAddr == ($past(machineState[mck_pkg::MSR_IP_BIT])
        ? 32'hfff0_0200 : 32'h0000_0200)) // see RULE_17
        else $error("vector address wrong");
    chk_stop_freeze: assert property ( // see RULE_18
        state_q == mck_pkg::MCK_STOP |-> haltCore && !checkstopOutputOe_n // see RULE_19
        ##1 $stable(save_restore_status_q) && $stable(cfg_q) && state_q == mck_pkg::MCK_STOP)
        else $error("checkstop not frozen");
    chk_input_forces: assert property ( // see RULE_20
        $fell(checkstopInputN) |-> ##[1:4] state_q == mck_pkg::MCK_STOP)
        else $error("checkstop input ignored");
endmodule : mck_unit
`default_nettype wire

// *** common/mck_pkg.sv ***
/*
 machine check / checkstop unit: shared constants, types and encodings.
 assumes big-endian bit numbering in the architecture, bit n at index 31-n.
*/
// Operation
// RULE_01 - enable set: listed errors start the exception
// RULE_02 - enable clear: error enters checkstop instead
// RULE_03 - config bit 0 masks machine check pin
// RULE_04 - config bit 2 gates address parity errors
// RULE_05 - config bit 3 gates data parity errors
// RULE_06 - config bit 15 changes only by write
// RULE_07 - hard reset clears flag, soft keeps it
// RULE_08 - transfer error exception is imprecise, unordered
// RULE_09 - zeroed block error may wait for writeback
// RULE_10 - address register gets executing instruction address
// RULE_11 - status image: clears, copies, recoverable bit
// RULE_12 - status bits 11-13 flag l2, pin, transfer
// RULE_13 - status bits 14-15 flag data, address parity
// RULE_14 - several causes set several status bits
// RULE_15 - entry clears most state bits, endian copied
// RULE_16 - fetch resumes at vector offset 0x200
// RULE_17 - prefix selects low or high vector base
// RULE_18 - checkstop halts and freezes within two cycles
// RULE_19 - checkstop drives open-drain checkstop output
// RULE_20 - checkstop input forces checkstop state
// RULE_21 - handler should set enable again soon
// RULE_22 - async pins synchronised before use
`default_nettype none
package mck_pkg;
    localparam int unsigned XLEN = 32;
    // configuration register fields
    localparam int unsigned CFG_PIN_EN_BIT = 31;
    localparam int unsigned CFG_ADDR_PAR_BIT = 29;
    localparam int unsigned CFG_DATA_PAR_BIT = 28;
    localparam int unsigned CFG_NOT_COLD_BIT = 16;
    localparam logic [31:0] CFG_RESET = 32'h0000_0000;
    localparam logic [31:0] SRR_RESET = 32'h0000_0000;
    // machine state fields
    localparam int unsigned MSR_VEC_BIT = 25;
    localparam int unsigned MSR_POW_BIT = 18;
    localparam int unsigned MSR_ILE_BIT = 16;
    localparam int unsigned MSR_EE_BIT = 15;
    localparam int unsigned MSR_FP_BIT = 13;
    localparam int unsigned MSR_ME_BIT = 12;
    localparam int unsigned MSR_FE0_BIT = 11;
    localparam int unsigned MSR_SE_BIT = 10;
    localparam int unsigned MSR_BE_BIT = 9;
    localparam int unsigned MSR_FE1_BIT = 8;
    localparam int unsigned MSR_IP_BIT = 6;
    localparam int unsigned MSR_IR_BIT = 5;
    localparam int unsigned MSR_DR_BIT = 4;
    localparam int unsigned MSR_PM_BIT = 2;
    localparam int unsigned MSR_RI_BIT = 1;
    localparam int unsigned MSR_LE_BIT = 0;
    // external enable (bit 16) is cleared on entry along with the rest
    localparam logic [31:0] MSR_CLEAR_MASK = 32'h0204_bf37;
    // status image: bits 6, 16-29 and 31 copied from machine state
    localparam logic [31:0] SAVE_RESTORE_STATUS_COPY_MASK = 32'h0200_fffd;
    localparam int unsigned SAVE_RESTORE_STATUS_RECOV_BIT = 1;
    localparam int unsigned SAVE_RESTORE_STATUS_CAUSE_LSB = 16;
    // vector placement
    localparam logic [31:0] VEC_OFFSET = 32'h0000_0200;
    localparam logic [31:0] VEC_BASE_LOW = 32'h0000_0000;
    localparam logic [31:0] VEC_BASE_HIGH = 32'hfff0_0000;
    localparam int unsigned FREEZE_CYCLES = 2;

    // special register select on the move-to/from port
    typedef enum logic [1:0] {
        MCK_SPR_CONFIG = 2'h0,
        MCK_SPR_ADDR = 2'h1,
        MCK_SPR_STATUS = 2'h2,
        MCK_SPR_NONE = 2'h3
    } mck_spr_t;

    typedef enum logic [1:0] {
        MCK_RUN = 2'b01,
        MCK_STOP = 2'b10
    } mck_state_t;

    // ordered as status image bits 11..15
    typedef struct packed {
        logic l2DataParity;
        logic pin;
        logic transferErr;
        logic dataParity;
        logic addrParity;
    } mck_cause_t;
endpackage : mck_pkg
`default_nettype wire

// *** logic/mck_sync.sv ***
/*
 two-flop level synchroniser, reset to a constant.
 assumes input is asynchronous; only the second flop leaves the module.
*/
`timescale 1ns/1ns
`default_nettype none
module mck_sync #(
    parameter int unsigned WIDTH = 1,
    parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
    input wire logic clock,
    input wire logic nrst,
    input wire logic [WIDTH-1:0] d,
    output logic [WIDTH-1:0] q
);
    logic [WIDTH-1:0] meta_q; // first stage, read only by q

    // plain shift; metastability settles in meta_q
    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            meta_q <= RESET_VAL;
            q <= RESET_VAL;
        end
        else
        begin
            meta_q <= d; // see RULE_22
            q <= meta_q;
        end
    end
endmodule : mck_sync
`default_nettype wire

// *** logic/mck_entry_image.sv ***
/*
 combinational images built on exception entry: status image,
 new machine state and vector address.
 assumes the caller registers the results.
*/
`timescale 1ns/1ns
`default_nettype none
module mck_entry_image (
    input wire logic [31:0] machineState,
    input wire mck_pkg::mck_cause_t causes,
    input wire logic recoverable,
    output logic [31:0] statusImage,
    output logic [31:0] stateImage,
    output logic [31:0] vectorAddr
);
    logic [31:0] causeField; // cause bits placed at 11..15
    logic [31:0] recovField; // recoverable bit placed at 30

    assign causeField = {27'h0, causes} << mck_pkg::SAVE_RESTORE_STATUS_CAUSE_LSB; // see RULE_14
    assign recovField = {31'h0, recoverable} << mck_pkg::SAVE_RESTORE_STATUS_RECOV_BIT;
    // reserved and cleared bits fall out of the mask as zero
    assign statusImage = (machineState & mck_pkg::SAVE_RESTORE_STATUS_COPY_MASK) // see RULE_11
        | causeField // see RULE_12 see RULE_13
        | recovField;
    // clear listed fields, then little-endian follows interrupt endian
    assign stateImage = ((machineState & ~mck_pkg::MSR_CLEAR_MASK) // see RULE_15
        & ~(32'h1 << mck_pkg::MSR_LE_BIT))
        | ({31'h0, machineState[mck_pkg::MSR_ILE_BIT]} << mck_pkg::MSR_LE_BIT);
    assign vectorAddr = (machineState[mck_pkg::MSR_IP_BIT] ? mck_pkg::VEC_BASE_HIGH // see RULE_17
        : mck_pkg::VEC_BASE_LOW) | mck_pkg::VEC_OFFSET; // see RULE_16
endmodule : mck_entry_image
`default_nettype wire

// *** test/mck_partner.sv ***
/*
 far-side model: bus controller error strobes and external checkstop logic.
 assumes the bench asks for events at a rising edge, one request a cycle.
*/
`timescale 1ns/1ns
`default_nettype none
module mck_partner (
    input wire logic clock,
    input wire logic nrst,
    input wire mck_pkg::mck_cause_t fire,
    input wire logic stopReq,
    output logic machineCheckPinN,
    output logic checkstopInputN,
    output logic transferErrorAck,
    output logic busAddrParityErr,
    output logic busDataParityErr,
    output logic l2DataParityErr
);
    logic [1:0] pinCount; // low time left on the pin
    // strobes last one cycle; the pin is held low three cycles so a level is seen, not a pulse
    always @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            // pins pulled up when released
            pinCount <= 2'h0;
            machineCheckPinN <= 1'b1;
            checkstopInputN <= 1'b1;
            transferErrorAck <= 1'b0;
            busAddrParityErr <= 1'b0;
            busDataParityErr <= 1'b0;
            l2DataParityErr <= 1'b0;
        end
        else
        begin
            transferErrorAck <= fire.transferErr;
            busAddrParityErr <= fire.addrParity;
            busDataParityErr <= fire.dataParity;
            l2DataParityErr <= fire.l2DataParity;
            pinCount <= fire.pin ? 2'h3 : (pinCount != 2'h0 ? pinCount - 2'h1 : 2'h0);
            machineCheckPinN <= !(fire.pin || pinCount > 2'h1);
            checkstopInputN <= !stopReq;
        end
    end
endmodule : mck_partner
`default_nettype wire

// *** test/testbench.sv ***
/*
 self-checking bench for the machine check unit with a reference model.
 assumes mck_partner on the far side; the bench plays the core.
*/
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, e) begin cmpCount++; if ((a) !== (e)) begin failures++; $display("[FAIL] t=%0t got %h exp %h", $time, (a), (e)); end end
module testbench;
    logic clock = 1'b0;
    logic nrst = 1'b1; // falls at time 0 so every async reset sees an edge
    logic sprWrite = 1'b0;
    mck_pkg::mck_spr_t sprSel = mck_pkg::MCK_SPR_NONE;
    logic [31:0] sprWrData = 32'h0;
    logic [31:0] machineState = 32'h0;
    logic [31:0] currentEa = 32'h0;
    logic recoverableIn = 1'b0;
    logic stopReq = 1'b0;
    mck_pkg::mck_cause_t fire = '0;
    wire logic mcPinN, stopInN, teAck, apErr, dpErr, l2Err;
    wire logic [31:0] sprRdData, machineStateOut, fetchAddr;
    wire logic machineStateLoad, fetchRedirect, haltCore, checkstopOutput, checkstopOutputOe_n;
    logic [31:0] seed = 32'hbe04bcc9;
    logic [31:0] cfg;
    logic [4:0] gated [3] = '{5'h08, 5'h02, 5'h01}; // pin, data, addr
    int failures = 0;
    int cmpCount = 0;

    // xorshift source, fixed start
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd

    initial
    begin
        forever #4 clock = ~clock;
    end

    mck_unit u_mck_unit (.clock(clock), .nrst(nrst), .machineCheckPinN(mcPinN), .checkstopInputN(stopInN),
        .transferErrorAck(teAck), .busAddrParityErr(apErr), .busDataParityErr(dpErr),
        .l2DataParityErr(l2Err), .machineState(machineState), .recoverableIn(recoverableIn),
        .currentEa(currentEa), .sprWrite(sprWrite), .sprSel(sprSel), .sprWrData(sprWrData),
        .sprRdData(sprRdData), .machineStateOut(machineStateOut), .machineStateLoad(machineStateLoad),
        .fetchAddr(fetchAddr), .fetchRedirect(fetchRedirect), .haltCore(haltCore),
        .checkstopOutput(checkstopOutput), .checkstopOutputOe_n(checkstopOutputOe_n));

    mck_partner u_mck_partner (.clock(clock), .nrst(nrst), .fire(fire), .stopReq(stopReq),
        .machineCheckPinN(mcPinN), .checkstopInputN(stopInN), .transferErrorAck(teAck),
        .busAddrParityErr(apErr), .busDataParityErr(dpErr), .l2DataParityErr(l2Err));

    // core side: new state applied on the edge after the load pulse
    always @(posedge clock)
    begin
        if (machineStateLoad === 1'b1)
            machineState <= machineStateOut;
    end

    task automatic conclude();
        if (failures == 0 && cmpCount > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : conclude

    // hard reset, then wait until requests are allowed
    task automatic doReset();
        nrst <= 1'b0;
        repeat (5) @(posedge clock);
        nrst <= 1'b1;
        repeat (4) @(posedge clock);
    endtask : doReset

    task automatic wr(input mck_pkg::mck_spr_t sel, input logic [31:0] d);
        sprSel <= sel;
        sprWrData <= d;
        sprWrite <= 1'b1;
        @(posedge clock);
        sprWrite <= 1'b0;
    endtask : wr

    // read data lands one edge after the select is taken
    task automatic rd(input mck_pkg::mck_spr_t sel, input logic [31:0] e);
        sprSel <= sel;
        @(posedge clock);
        @(negedge clock);
        `CHK(sprRdData, e)
        @(posedge clock);
    endtask : rd

    // raise causes, wait a bounded time for the answer and compare with the model
    task automatic hit(input logic [31:0] ms, input logic [4:0] c, input logic stop, input logic take,
        input logic halt, input int lat);
        int n;
        logic [31:0] ea;
        logic rec;
        ea = rnd();
        rec = ea[3];
        machineState <= ms;
        currentEa <= ea;
        recoverableIn <= rec;
        fire <= c;
        stopReq <= stop;
        @(posedge clock);
        fire <= '0;
        n = 1;
        @(negedge clock);
        while (fetchRedirect !== 1'b1 && haltCore !== 1'b1 && n < 8)
        begin
            @(negedge clock);
            n++;
        end
        `CHK(n, lat)
        `CHK(fetchRedirect, take)
        `CHK(machineStateLoad, take)
        `CHK(checkstopOutputOe_n, ~halt)
        `CHK(checkstopOutput, 1'b0)
        if (n == 8 && lat != 8)
            conclude();
        if (take)
        begin
            `CHK(fetchAddr, (ms[6] ? 32'hfff0_0000 : 32'h0) | 32'h0000_0200)
            `CHK(machineStateOut, (ms & ~mck_pkg::MSR_CLEAR_MASK) | {31'h0, ms[16]})
            @(negedge clock);
            `CHK(fetchRedirect, 1'b0)
            @(posedge clock);
            rd(mck_pkg::MCK_SPR_ADDR, ea);
            rd(mck_pkg::MCK_SPR_STATUS, (ms & 32'h0200_fffd) | {11'h0, c, 16'h0} | {30'h0, rec, 1'b0});
        end
        else
            @(posedge clock);
        `CHK(haltCore, halt)
    endtask : hit

    initial
    begin
        doReset();
        for (int s = 0; s < 4; s++)
            rd(mck_pkg::mck_spr_t'(s), 32'h0);
        cfg = rnd();
        wr(mck_pkg::MCK_SPR_CONFIG, cfg);
        rd(mck_pkg::MCK_SPR_CONFIG, cfg);
        wr(mck_pkg::MCK_SPR_NONE, ~cfg);
        rd(mck_pkg::MCK_SPR_CONFIG, cfg);
        // every source enabled, software flag set so the later hard reset shows it cleared
        cfg = cfg | 32'hb001_0000;
        wr(mck_pkg::MCK_SPR_CONFIG, cfg);
        for (int i = 0; i < 6; i++)
            hit(rnd() | 32'h1000, (i == 5) ? 5'h17 : 5'h01 << i, 1'b0, 1'b1, 1'b0, (i == 3) ? 4 : 2);
        // sources masked, and with the enable clear: neither exception nor checkstop
        wr(mck_pkg::MCK_SPR_CONFIG, cfg & 32'h4fff_ffff);
        for (int i = 0; i < 3; i++)
            hit(rnd() & ~32'h1000, gated[i], 1'b0, 1'b0, 1'b0, 8);
        wr(mck_pkg::MCK_SPR_CONFIG, cfg);
        rd(mck_pkg::MCK_SPR_CONFIG, cfg);
        // enable still clear as the handler left it: a further cause stops the core
        hit(rnd() & ~32'h1000, 5'h10, 1'b0, 1'b0, 1'b1, 2);
        // frozen: write ignored and read data held
        wr(mck_pkg::MCK_SPR_ADDR, ~cfg);
        rd(mck_pkg::MCK_SPR_ADDR, cfg);
        doReset();
        rd(mck_pkg::MCK_SPR_CONFIG, 32'h0);
        hit(rnd() | 32'h1000, 5'h00, 1'b1, 1'b0, 1'b1, 4);
        conclude();
    end
endmodule : testbench
`default_nettype wire
